// file: rtl/mpcpc_pkg.sv
// Shared constants and frame carriers for the MPCP frame codec.
// Assumes one 25 MHz clock and an active-low asynchronous reset.
`default_nettype none

package mpcpc_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [15:0] OP_GATE = 16'h0002;
  localparam logic [15:0] OP_REPORT = 16'h0003;
  localparam logic [15:0] OP_REGREQ = 16'h0004;
  localparam int HDR_LEN = 6;
  localparam int PAYLOAD_LEN = 40;
  localparam int FRAME_LEN = HDR_LEN + PAYLOAD_LEN;
  localparam logic [5:0] LAST_IDX = 6'h2d;
  localparam int MAX_GRANTS = 4;
  localparam int MAX_QSETS = 2;
  localparam int NUM_QUEUES = 8;
  localparam logic [7:0] RR_REGISTER = 8'h01;
  localparam logic [7:0] RR_DEREGISTER = 8'h03;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LLID = 4'h4;
  localparam logic [3:0] REG_RXSTAT = 4'h8;
  localparam logic [3:0] REG_TXCNT = 4'hc;
  localparam int CTRL_FEC_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] LLID_RST = 16'h0000;
  // ----------------------------------------
  // Queue report overhead, in time quanta
  // ----------------------------------------
  localparam logic [15:0] IFG_TQ = 16'h0001;
  localparam int FEC_SHIFT = 3;

  typedef enum logic [1:0] {MPCPC_GATE, MPCPC_REPORT, MPCPC_REGREQ} mpcpc_kind_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic disc;
    logic [MAX_GRANTS-1:0] force_rpt;
    logic [MAX_GRANTS-1:0][31:0] start;
    logic [MAX_GRANTS-1:0][15:0] len;
    logic [15:0] sync;
  } mpcpc_gate_t;

  typedef struct packed {
    logic [7:0] qsets;
    logic [MAX_QSETS-1:0][7:0] bitmap;
    logic [MAX_QSETS-1:0][NUM_QUEUES-1:0][15:0] queue;
  } mpcpc_report_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] pending;
  } mpcpc_regreq_t;
endpackage

`default_nettype wire

// file: rtl/mpcpc_qadj.sv
// Queue report adjuster: adds gap and parity overhead to a raw request.
// Assumes the caller samples the result on its own clock.
`default_nettype none

module mpcpc_qadj (
  input wire logic [15:0] raw,
  input wire logic fec_en,
  output logic [15:0] adj
);
  logic [17:0] sum;

  always_comb begin
    sum = {2'b00, raw};
    // Empty queue stays empty, asking for nothing
    if (raw != 16'h0000) begin
      sum = sum + {2'b00, mpcpc_pkg::IFG_TQ};
      if (fec_en) begin
        sum = sum + {2'b00, (raw >> mpcpc_pkg::FEC_SHIFT)} + 18'h00001;
      end
    end
    // Saturate rather than wrap to a small request
    adj = (sum[17:16] != 2'b00) ? 16'hffff : sum[15:0];
  end
endmodule

`default_nettype wire

// file: rtl/mpcpc_codec.sv
// Grant, report and registration request frame encoder and decoder.
// Assumes a byte stream MAC on the same clock, opcode first, 46 bytes.
`default_nettype none

module mpcpc_codec #(
  parameter logic [15:0] BCAST_LLID = 16'hffff
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] local_time,
  input wire logic tx_req,
  input wire mpcpc_pkg::mpcpc_kind_t tx_kind,
  input wire mpcpc_pkg::mpcpc_gate_t tx_gate,
  input wire mpcpc_pkg::mpcpc_report_t tx_report,
  input wire mpcpc_pkg::mpcpc_regreq_t tx_regreq,
  output logic tx_busy,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_sof,
  output logic tx_eof,
  output logic [15:0] tx_llid,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  output logic rx_gate_valid,
  output mpcpc_pkg::mpcpc_gate_t rx_gate,
  output logic rx_report_valid,
  output mpcpc_pkg::mpcpc_report_t rx_report,
  output logic rx_regreq_valid,
  output mpcpc_pkg::mpcpc_regreq_t rx_regreq,
  output logic [31:0] rx_timestamp
);
  typedef enum logic {TX_IDLE, TX_SEND} mpcpc_txst_t;

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] llid_q;
  logic [7:0] rx_gate_cnt_q;
  logic [7:0] rx_rep_cnt_q;
  logic [7:0] rx_rr_cnt_q;
  logic [7:0] rx_drop_cnt_q;
  logic [31:0] tx_cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= mpcpc_pkg::CTRL_RST;
      llid_q <= mpcpc_pkg::LLID_RST;
    end else if (reg_wr) begin
      if (reg_addr == mpcpc_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      if (reg_addr == mpcpc_pkg::REG_LLID) begin
        llid_q <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        mpcpc_pkg::REG_CTRL: reg_rdata <= ctrl_q;
        mpcpc_pkg::REG_LLID: reg_rdata <= {16'h0000, llid_q};
        mpcpc_pkg::REG_RXSTAT: begin
          reg_rdata <= {rx_drop_cnt_q, rx_rr_cnt_q, rx_rep_cnt_q, rx_gate_cnt_q};
        end
        mpcpc_pkg::REG_TXCNT: reg_rdata <= tx_cnt_q;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Queue report adjustment
  // ----------------------------------------
  logic [mpcpc_pkg::MAX_QSETS-1:0][mpcpc_pkg::NUM_QUEUES-1:0][15:0] adj;

  for (genvar s = 0; s < mpcpc_pkg::MAX_QSETS; s++) begin : g_set
    for (genvar q = 0; q < mpcpc_pkg::NUM_QUEUES; q++) begin : g_q
      mpcpc_qadj u_qadj (
        .raw(tx_report.queue[s][q]),
        .fec_en(ctrl_q[mpcpc_pkg::CTRL_FEC_BIT]),
        .adj(adj[s][q])
      );
    end
  end

  // ----------------------------------------
  // Frame builder
  // ----------------------------------------
  logic [7:0] fb [mpcpc_pkg::FRAME_LEN];
  logic [5:0] used;
  logic [2:0] gcnt;
  logic [7:0] qsets;

  always_comb begin
    int p;
    p = mpcpc_pkg::HDR_LEN + 1;
    for (int i = 0; i < mpcpc_pkg::FRAME_LEN; i++) begin
      fb[i] = 8'h00;
    end
    {fb[2], fb[3], fb[4], fb[5]} = local_time;
    gcnt = (tx_gate.cnt > 3'h4) ? 3'h4 : tx_gate.cnt;
    if (tx_gate.disc) begin
      gcnt = 3'h1;
    end
    qsets = (tx_report.qsets > 8'h02) ? 8'h02 : tx_report.qsets;
    case (tx_kind)
      mpcpc_pkg::MPCPC_GATE: begin
        {fb[0], fb[1]} = mpcpc_pkg::OP_GATE;
        fb[6] = {tx_gate.force_rpt, tx_gate.disc, gcnt};
        // Zero count leaves only the timestamp and the flags byte
        for (int g = 0; g < mpcpc_pkg::MAX_GRANTS; g++) begin
          if (g < gcnt) begin
            {fb[p], fb[p+1], fb[p+2], fb[p+3]} = tx_gate.start[g];
            {fb[p+4], fb[p+5]} = tx_gate.len[g];
            p = p + 6;
          end
        end
        if (tx_gate.disc) begin
          {fb[p], fb[p+1]} = tx_gate.sync;
          p = p + 2;
        end
      end
      mpcpc_pkg::MPCPC_REPORT: begin
        {fb[0], fb[1]} = mpcpc_pkg::OP_REPORT;
        fb[6] = qsets;
        for (int s = 0; s < mpcpc_pkg::MAX_QSETS; s++) begin
          if (s < qsets) begin
            fb[p] = tx_report.bitmap[s];
            p = p + 1;
            for (int q = 0; q < mpcpc_pkg::NUM_QUEUES; q++) begin
              if (tx_report.bitmap[s][q]) begin
                {fb[p], fb[p+1]} = adj[s][q];
                p = p + 2;
              end
            end
          end
        end
      end
      default: begin
        {fb[0], fb[1]} = mpcpc_pkg::OP_REGREQ;
        fb[6] = tx_regreq.flags;
        fb[7] = tx_regreq.pending;
        p = p + 1;
      end
    endcase
    used = p[5:0];
  end

  // ----------------------------------------
  // Transmit serialiser
  // ----------------------------------------
  mpcpc_txst_t tx_st_q;
  logic [7:0] tx_buf_q [mpcpc_pkg::FRAME_LEN];
  logic [5:0] tx_idx_q;
  logic [5:0] tx_used_q;
  mpcpc_pkg::mpcpc_kind_t tx_kind_q;
  logic tx_beat;
  logic tx_take;

  assign tx_busy = (tx_st_q == TX_SEND);
  assign tx_valid = (tx_st_q == TX_SEND);
  assign tx_beat = tx_valid && tx_ready;
  assign tx_take = tx_req && !tx_busy;
  assign tx_data = tx_buf_q[0];
  assign tx_sof = tx_valid && (tx_idx_q == 6'h00);
  assign tx_eof = tx_valid && (tx_idx_q == mpcpc_pkg::LAST_IDX);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q <= TX_IDLE;
      tx_idx_q <= 6'h00;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_take) begin
            tx_st_q <= TX_SEND;
            tx_idx_q <= 6'h00;
          end
        end
        TX_SEND: begin
          if (tx_beat) begin
            tx_idx_q <= tx_idx_q + 6'h01;
            if (tx_eof) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Shifting keeps the data output straight off a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < mpcpc_pkg::FRAME_LEN; i++) begin
        tx_buf_q[i] <= 8'h00;
      end
    end else if (tx_take) begin
      for (int i = 0; i < mpcpc_pkg::FRAME_LEN; i++) begin
        tx_buf_q[i] <= fb[i];
      end
    end else if (tx_beat) begin
      for (int i = 0; i < mpcpc_pkg::FRAME_LEN - 1; i++) begin
        tx_buf_q[i] <= tx_buf_q[i+1];
      end
      tx_buf_q[mpcpc_pkg::FRAME_LEN-1] <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_kind_q <= mpcpc_pkg::MPCPC_GATE;
      tx_used_q <= 6'h00;
      tx_llid <= 16'h0000;
      tx_cnt_q <= 32'h0000_0000;
    end else if (tx_take) begin
      tx_kind_q <= tx_kind;
      tx_used_q <= used;
      tx_cnt_q <= tx_cnt_q + 32'h0000_0001;
      if (tx_kind == mpcpc_pkg::MPCPC_REGREQ) begin
        tx_llid <= BCAST_LLID;
      end else if (tx_kind == mpcpc_pkg::MPCPC_GATE && tx_gate.disc) begin
        tx_llid <= BCAST_LLID;
      end else begin
        tx_llid <= llid_q;
      end
    end
  end

  // ----------------------------------------
  // Receive collector and parser
  // ----------------------------------------
  logic [7:0] rx_buf_q [mpcpc_pkg::FRAME_LEN];
  logic [5:0] rx_idx_q;
  logic rx_on_q;
  logic rx_done_q;
  logic rx_drop_q;
  logic [15:0] rx_op;
  logic [7:0] rx_flags;
  logic gate_ok;
  logic rr_ok;
  mpcpc_pkg::mpcpc_gate_t pg;
  mpcpc_pkg::mpcpc_report_t pr;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_idx_q <= 6'h00;
      rx_on_q <= 1'b0;
      rx_done_q <= 1'b0;
      for (int i = 0; i < mpcpc_pkg::FRAME_LEN; i++) begin
        rx_buf_q[i] <= 8'h00;
      end
    end else begin
      rx_done_q <= 1'b0;
      if (rx_valid && (rx_sof || rx_on_q)) begin
        rx_buf_q[rx_sof ? 6'h00 : rx_idx_q] <= rx_data;
        rx_idx_q <= (rx_sof ? 6'h00 : rx_idx_q) + 6'h01;
        rx_on_q <= 1'b1;
        if (!rx_sof && rx_idx_q == mpcpc_pkg::LAST_IDX) begin
          rx_on_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    int p;
    p = mpcpc_pkg::HDR_LEN + 1;
    rx_op = {rx_buf_q[0], rx_buf_q[1]};
    rx_flags = rx_buf_q[6];
    pg = '0;
    pr = '0;
    pg.cnt = rx_flags[2:0];
    pg.disc = rx_flags[3];
    pg.force_rpt = rx_flags[7:4];
    // Start-time order is trusted, not rechecked
    for (int g = 0; g < mpcpc_pkg::MAX_GRANTS; g++) begin
      if (g < pg.cnt) begin
        pg.start[g] = {rx_buf_q[p], rx_buf_q[p+1], rx_buf_q[p+2], rx_buf_q[p+3]};
        pg.len[g] = {rx_buf_q[p+4], rx_buf_q[p+5]};
        p = p + 6;
      end
    end
    if (pg.disc) begin
      pg.sync = {rx_buf_q[p], rx_buf_q[p+1]};
    end
    gate_ok = (pg.cnt <= 3'h4) && (!pg.disc || pg.cnt == 3'h1);
    p = mpcpc_pkg::HDR_LEN + 1;
    pr.qsets = rx_flags;
    // Sets past the second are not decoded
    for (int s = 0; s < mpcpc_pkg::MAX_QSETS; s++) begin
      if (s < pr.qsets) begin
        pr.bitmap[s] = rx_buf_q[p];
        p = p + 1;
        for (int q = 0; q < mpcpc_pkg::NUM_QUEUES; q++) begin
          if (pr.bitmap[s][q]) begin
            pr.queue[s][q] = {rx_buf_q[p], rx_buf_q[p+1]};
            p = p + 2;
          end
        end
      end
    end
    rr_ok = (rx_flags == mpcpc_pkg::RR_REGISTER) || (rx_flags == mpcpc_pkg::RR_DEREGISTER);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_gate_valid <= 1'b0;
      rx_report_valid <= 1'b0;
      rx_regreq_valid <= 1'b0;
      rx_drop_q <= 1'b0;
      rx_gate <= '0;
      rx_report <= '0;
      rx_regreq <= '0;
      rx_timestamp <= 32'h0000_0000;
    end else begin
      rx_gate_valid <= rx_done_q && rx_op == mpcpc_pkg::OP_GATE && gate_ok;
      rx_report_valid <= rx_done_q && rx_op == mpcpc_pkg::OP_REPORT;
      rx_regreq_valid <= rx_done_q && rx_op == mpcpc_pkg::OP_REGREQ && rr_ok;
      rx_drop_q <= rx_done_q && !((rx_op == mpcpc_pkg::OP_GATE && gate_ok)
          || rx_op == mpcpc_pkg::OP_REPORT || (rx_op == mpcpc_pkg::OP_REGREQ && rr_ok));
      if (rx_done_q) begin
        rx_gate <= pg;
        rx_report <= pr;
        rx_regreq <= '{flags: rx_flags, pending: rx_buf_q[7]};
        rx_timestamp <= {rx_buf_q[2], rx_buf_q[3], rx_buf_q[4], rx_buf_q[5]};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_gate_cnt_q <= 8'h00;
      rx_rep_cnt_q <= 8'h00;
      rx_rr_cnt_q <= 8'h00;
      rx_drop_cnt_q <= 8'h00;
    end else begin
      rx_gate_cnt_q <= rx_gate_cnt_q + {7'h00, rx_gate_valid};
      rx_rep_cnt_q <= rx_rep_cnt_q + {7'h00, rx_report_valid};
      rx_rr_cnt_q <= rx_rr_cnt_q + {7'h00, rx_regreq_valid};
      rx_drop_cnt_q <= rx_drop_cnt_q + {7'h00, rx_drop_q};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence tx_launch_s;
    tx_req && !tx_busy;
  endsequence

  sequence tx_first_s;
    tx_valid && tx_sof && tx_data == 8'h00;
  endsequence

  tx_start_a: assert property (tx_launch_s |=> tx_first_s)
    else $error("frame did not start with opcode high byte");
  gate_opcode_a: assert property (
    tx_valid && tx_idx_q == 6'h01 && tx_kind_q == mpcpc_pkg::MPCPC_GATE |-> tx_data == 8'h02)
    else $error("grant opcode wrong");
  report_opcode_a: assert property (
    tx_valid && tx_idx_q == 6'h01 && tx_kind_q == mpcpc_pkg::MPCPC_REPORT |-> tx_data == 8'h03)
    else $error("report opcode wrong");
  regreq_opcode_a: assert property (
    tx_valid && tx_idx_q == 6'h01 && tx_kind_q == mpcpc_pkg::MPCPC_REGREQ |-> tx_data == 8'h04)
    else $error("registration request opcode wrong");
  disc_single_a: assert property (
    tx_valid && tx_idx_q == 6'h06 && tx_kind_q == mpcpc_pkg::MPCPC_GATE && tx_data[3]
    |-> tx_data[2:0] == 3'h1)
    else $error("discovery grant count not one");
  pad_zero_a: assert property (tx_valid && tx_idx_q >= tx_used_q |-> tx_data == 8'h00)
    else $error("padding not zero");
  report_llid_a: assert property (
    tx_valid && tx_kind_q == mpcpc_pkg::MPCPC_REPORT
    |-> tx_llid == llid_q && (tx_sof || $stable(tx_llid)))
    else $error("report link id not unicast");
  regreq_llid_a: assert property (
    tx_valid && tx_kind_q == mpcpc_pkg::MPCPC_REGREQ |-> tx_llid == BCAST_LLID)
    else $error("registration request not broadcast");
  rx_regreq_flags_a: assert property (
    rx_regreq_valid |-> rx_regreq.flags == 8'h01 || rx_regreq.flags == 8'h03)
    else $error("reserved registration flags accepted");
  rx_gate_cnt_a: assert property (
    rx_gate_valid |-> rx_gate.cnt <= 3'h4 && (!rx_gate.disc || rx_gate.cnt == 3'h1))
    else $error("bad grant count accepted");
  rx_verdict_a: assert property (
    rx_done_q |=> $onehot({rx_gate_valid, rx_report_valid, rx_regreq_valid, rx_drop_q}))
    else $error("received frame without one verdict");
  qadj_up_a: assert property (
    tx_report.queue[0][1] != 16'h0000 && tx_report.queue[0][1] != 16'hffff
    |-> adj[0][1] > tx_report.queue[0][1])
    else $error("queue report not adjusted upward");
endmodule

`default_nettype wire

// file: verification/mpcpc_peer.sv
// Far-side MAC control peer: byte sink with random stalls, byte source.
// Assumes the codec's clock; the bench seeds the random stream.
`default_nettype none

module mpcpc_peer (
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_sof,
  input wire logic tx_eof,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cap [46];
  int n = 0;
  int got = 0;
  int sof_bad = 0;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'h00;
  end

  // ------------------------------
  // Sink, stalls at random
  // ------------------------------
  always @(posedge clk) begin
    tx_ready <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
    if (tx_valid && tx_ready) begin
      cap[n] <= tx_data;
      // Start marker must sit on the first byte only
      if (tx_sof != (n == 0)) begin
        sof_bad <= sof_bad + 1;
      end
      n <= tx_eof ? 0 : n + 1;
      if (tx_eof) begin
        got <= got + 1;
      end
    end
  end

  // ------------------------------
  // Source, one whole frame
  // ------------------------------
  task automatic send(input logic [7:0] f [46]);
    for (int i = 0; i < 46; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= f[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    // Released line must not show the stale byte
    rx_data <= ~f[45];
  endtask
endmodule

`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the grant, report and registration codec.
// Assumes mpcpc_pkg, mpcpc_codec and mpcpc_peer are compiled first.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BC = 16'hffff;
  localparam int NIT = 30;
  int fails = 0;
  int check_count = 0;
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] local_time = 32'h0;
  logic tx_req = 1'b0;
  mpcpc_pkg::mpcpc_kind_t tx_kind = mpcpc_pkg::MPCPC_GATE;
  mpcpc_pkg::mpcpc_gate_t tx_gate = '0;
  mpcpc_pkg::mpcpc_report_t tx_report = '0;
  mpcpc_pkg::mpcpc_regreq_t tx_regreq = '0;
  logic tx_busy;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic tx_sof;
  logic tx_eof;
  logic [15:0] tx_llid;
  logic rx_valid;
  logic rx_sof;
  logic [7:0] rx_data;
  logic rx_gate_valid;
  logic rx_report_valid;
  logic rx_regreq_valid;
  mpcpc_pkg::mpcpc_gate_t rx_gate;
  mpcpc_pkg::mpcpc_report_t rx_report;
  mpcpc_pkg::mpcpc_regreq_t rx_regreq;
  logic [31:0] rx_timestamp;
  logic stall = 1'b0;
  logic [15:0] llid;
  logic fec;
  logic [7:0] eq [$];
  logic [7:0] fr [46];
  mpcpc_pkg::mpcpc_gate_t g;
  mpcpc_pkg::mpcpc_report_t rp;
  mpcpc_pkg::mpcpc_regreq_t rq;

  always #20 clk = ~clk;

  mpcpc_codec #(.BCAST_LLID(BC)) DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .local_time(local_time), .tx_req(tx_req), .tx_kind(tx_kind), .tx_gate(tx_gate),
    .tx_report(tx_report), .tx_regreq(tx_regreq), .tx_busy(tx_busy), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_llid(tx_llid),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data), .rx_gate_valid(rx_gate_valid),
    .rx_gate(rx_gate), .rx_report_valid(rx_report_valid), .rx_report(rx_report),
    .rx_regreq_valid(rx_regreq_valid), .rx_regreq(rx_regreq), .rx_timestamp(rx_timestamp));

  mpcpc_peer peer (.clk(clk), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data));

  // ------------------------------
  // Expected frames
  // ------------------------------
  function automatic logic [15:0] adj(logic [15:0] q, logic f);
    int v;
    v = q + 1 + (f ? (q >> 3) + 1 : 0);
    return (q == 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
  endfunction

  function automatic void p16(logic [15:0] v);
    eq.push_back(v[15:8]);
    eq.push_back(v[7:0]);
  endfunction

  function automatic void p32(logic [31:0] v);
    p16(v[31:16]);
    p16(v[15:0]);
  endfunction

  function automatic void expect_frame(mpcpc_pkg::mpcpc_kind_t k, logic [31:0] ts, int n);
    eq.delete();
    p16(k == mpcpc_pkg::MPCPC_GATE ? mpcpc_pkg::OP_GATE : k == mpcpc_pkg::MPCPC_REPORT ?
        mpcpc_pkg::OP_REPORT : mpcpc_pkg::OP_REGREQ);
    p32(ts);
    case (k)
      mpcpc_pkg::MPCPC_GATE: begin
        eq.push_back({g.force_rpt, g.disc, g.cnt});
        for (int i = 0; i < g.cnt; i++) begin
          p32(g.start[i]);
          p16(g.len[i]);
        end
        if (g.disc) p16(g.sync);
      end
      mpcpc_pkg::MPCPC_REPORT: begin
        eq.push_back(8'(n));
        for (int s = 0; s < n; s++) begin
          eq.push_back(rp.bitmap[s]);
          for (int b = 0; b < 8; b++)
            if (rp.bitmap[s][b]) p16(adj(rp.queue[s][b], fec));
        end
      end
      default: begin
        eq.push_back(rq.flags);
        eq.push_back(rq.pending);
      end
    endcase
    while (eq.size() < 46) eq.push_back(8'h00);
  endfunction

  // ------------------------------
  // Bus and stream tasks
  // ------------------------------
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic rx_wait(output logic [2:0] v);
    v = 3'b000;
    for (int w = 0; w < 8 && v == 3'b000; w++) begin
      @(posedge clk);
      #1;
      v = {rx_regreq_valid, rx_report_valid, rx_gate_valid};
    end
  endtask

  task automatic run_frame(input mpcpc_pkg::mpcpc_kind_t k);
    int base;
    int n;
    logic [31:0] ts;
    logic [2:0] v;
    ts = $urandom;
    base = peer.got;
    n = (rp.qsets > 8'd2) ? 2 : int'(rp.qsets);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_kind <= k;
    tx_gate <= g;
    tx_report <= rp;
    tx_regreq <= rq;
    local_time <= ts;
    @(posedge clk);
    tx_req <= 1'b0;
    repeat (3) @(posedge clk);
    // Mid-frame request must be dropped
    tx_req <= 1'b1;
    @(posedge clk);
    tx_req <= 1'b0;
    for (int w = 0; w < 500 && peer.got == base; w++) begin
      @(posedge clk);
      #1;
    end
    expect_frame(k, ts, n);
    `CHK("tx frame", base + 1, peer.got)
    `CHK("tx_sof", 0, peer.sof_bad)
    for (int i = 0; i < 46; i++) `CHK("tx byte", eq[i], peer.cap[i])
    `CHK("tx_llid", (k == mpcpc_pkg::MPCPC_REGREQ || (k == mpcpc_pkg::MPCPC_GATE && g.disc))
      ? BC : llid, tx_llid)
    repeat (2) @(posedge clk);
    #1;
    `CHK("tx_busy", 1'b0, tx_busy)
    for (int i = 0; i < 46; i++) fr[i] = peer.cap[i];
    peer.send(fr);
    rx_wait(v);
    `CHK("rx pulse", 3'(1 << k), v)
    `CHK("rx_timestamp", ts, rx_timestamp)
    case (k)
      mpcpc_pkg::MPCPC_GATE: begin
        `CHK("rx flags", {g.force_rpt, g.disc, g.cnt},
          {rx_gate.force_rpt, rx_gate.disc, rx_gate.cnt})
        for (int i = 0; i < g.cnt; i++) begin
          `CHK("rx start", g.start[i], rx_gate.start[i])
          `CHK("rx len", g.len[i], rx_gate.len[i])
        end
        if (g.disc) `CHK("rx sync", g.sync, rx_gate.sync)
      end
      mpcpc_pkg::MPCPC_REPORT: begin
        `CHK("rx qsets", 8'(n), rx_report.qsets)
        for (int s = 0; s < n; s++) begin
          `CHK("rx bitmap", rp.bitmap[s], rx_report.bitmap[s])
          for (int b = 0; b < 8; b++)
            if (rp.bitmap[s][b])
              `CHK("rx queue", adj(rp.queue[s][b], fec), rx_report.queue[s][b])
        end
      end
      default: `CHK("rx regreq", rq, rx_regreq)
    endcase
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial begin
    logic [2:0] v;
    void'($urandom(23));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    reg_check(mpcpc_pkg::REG_CTRL, mpcpc_pkg::CTRL_RST);
    `CHK("reset out", 18'h0, {tx_busy, rx_gate_valid, tx_llid})
    reg_check(mpcpc_pkg::REG_LLID, 32'(mpcpc_pkg::LLID_RST));
    reg_write(4'h2, $urandom);
    reg_check(4'h2, 32'h0);
    reg_check(mpcpc_pkg::REG_TXCNT, 32'h0);
    $display("test registers done");
    for (int it = 0; it < NIT; it++) begin
      llid = 16'($urandom);
      fec = 1'($urandom);
      reg_write(mpcpc_pkg::REG_LLID, {16'h0000, llid});
      reg_write(mpcpc_pkg::REG_CTRL, {31'h0, fec});
      stall <= 1'($urandom);
      g.cnt = (it == 0) ? 3'h0 : (it == 6) ? 3'h4 : 3'($urandom_range(0, 4));
      g.disc = (it == 3) || (g.cnt == 3'h1 && 1'($urandom));
      if (g.disc) g.cnt = 3'h1;
      g.force_rpt = 4'($urandom);
      g.sync = 16'($urandom);
      for (int i = 0; i < 4; i++) begin
        g.start[i] = 32'(i) * 32'h1000_0000 + $urandom_range(0, 32'h0fff_ffff);
        g.len[i] = 16'($urandom);
      end
      rp.qsets = (it == 1) ? 8'h03 : 8'($urandom_range(0, 2));
      rp.bitmap = (it == 1) ? 16'hffff : 16'($urandom);
      for (int b = 0; b < 16; b++) rp.queue[b / 8][b % 8] = 16'($urandom);
      rp.queue[0][0] = 16'h0000;
      rp.queue[1][7] = 16'hffff;
      rq.flags = 1'($urandom) ? mpcpc_pkg::RR_REGISTER : mpcpc_pkg::RR_DEREGISTER;
      rq.pending = 8'($urandom);
      run_frame(mpcpc_pkg::mpcpc_kind_t'(it % 3));
    end
    $display("test frames done");
    for (int j = 0; j < 6; j++) begin
      fr = '{default: 8'h00};
      fr[1] = (j == 0) ? 8'h05 : (j < 3) ? 8'h02 : 8'h04;
      fr[6] = (j == 1) ? 8'h05 : (j == 2) ? 8'h0a : (j == 4) ? 8'h02 :
        (j == 5) ? 8'($urandom_range(4, 255)) : 8'h00;
      peer.send(fr);
      rx_wait(v);
      `CHK("rx refused", 3'b000, v)
    end
    $display("test refusals done");
    reg_check(mpcpc_pkg::REG_RXSTAT, {8'd6, 8'(NIT / 3), 8'(NIT / 3), 8'(NIT / 3)});
    reg_check(mpcpc_pkg::REG_TXCNT, 32'(NIT));
    $display("test counters done");
    wrap_up();
  end

  initial begin
    #(40 * 40000);
    fails++;
    wrap_up();
  end
endmodule

`default_nettype wire
